// file: hw/radio_ctrl_pkg.sv
// Package: register map, mode bits, sequencer timing for the radio control
package radio_ctrl_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [7:0] idx_device_state = 8'h02;
   localparam logic [7:0] idx_flags_one = 8'h03;
   localparam logic [7:0] idx_flags_two = 8'h04;
   localparam logic [7:0] idx_mask_one = 8'h05;
   localparam logic [7:0] idx_mask_two = 8'h06;
   localparam logic [7:0] idx_mode_ctrl = 8'h07;
   localparam logic [7:0] idx_xtal_ctrl = 8'h62;
   localparam logic [7:0] idx_seq_cfg = 8'h80;
   localparam logic [7:0] idx_event_raise = 8'h81;
   localparam logic [7:0] idx_sequence = 8'h82;
   // Operating mode register fields, then crystal control and sequencer config bits
   localparam int mode_xton_bit = 0;
   localparam int mode_pllon_bit = 1;
   localparam int mode_rxon_bit = 2;
   localparam int mode_txon_bit = 3;
   localparam int mode_lbd_bit = 5;
   localparam int mode_wt_bit = 6;
   localparam logic [7:0] mode_sleep_value = 8'h40;
   localparam int mode_lbd_en_bit = 5;
   localparam int xtal_bufovr_bit = 1;
   localparam int seq_skipcal_bit = 0;
   // Reset values
   localparam logic [7:0] mode_ctrl_reset = 8'h01;
   localparam logic [7:0] xtal_ctrl_reset = 8'h00;
   localparam logic [7:0] seq_cfg_reset = 8'h00;
   localparam logic [7:0] mask_one_reset = 8'h00;
   localparam logic [7:0] mask_two_reset = 8'h01;
   // Chip power state codes
   localparam logic [1:0] cps_idle = 2'h0;
   localparam logic [1:0] cps_rx = 2'h1;
   localparam logic [1:0] cps_tx = 2'h2;
   // Timer lengths in microseconds, cycles at 200 MHz
   localparam int clk_mhz = 200;
   localparam int xtal_wait_us = 600;
   localparam int pll_settle_us = 100;
   localparam int cal_time_us = 50;
   localparam int pa_ramp_us = 5;
   localparam int xtal_wait_cycles = xtal_wait_us * clk_mhz;
   localparam int pll_settle_cycles = pll_settle_us * clk_mhz;
   localparam int cal_cycles = cal_time_us * clk_mhz;
   localparam int pa_ramp_cycles = pa_ramp_us * clk_mhz;
   typedef enum logic [3:0] {
      st_idle, st_regs, st_xtal, st_pll, st_cal, st_settle, st_pa,
      st_tx, st_rxen, st_rx
   } seq_state_e;
endpackage

// file: hw/radio_mode_sequencer_irq.sv
// Radio mode control, transmit/receive sequencer and event interrupts
// Contract
// RULE1 - Writing 40h selects sleep: only low-power regulator and wake timer
// RULE2 - Host reads event flags while irq low in idle for least current
// RULE3 - Sensor mode with battery bit set enables the battery detector
// RULE4 - Crystal-on bit enters ready; crystal stays on, skips start-up
// RULE5 - Host clears crystal buffer override bit 1 before leaving ready
// RULE6 - PLL-on enters tune; crystal enabled automatically with PLL locked
// RULE7 - Transmit-on bit in idle starts sequencer toward transmit
// RULE8 - Transmit: regulators, crystal, PLL, calibrate, settle, ramp, send
// RULE9 - Calibration skipped when skip bit is one; bit resets to zero
// RULE10 - Steps already active in previous idle mode are omitted
// RULE11 - Without skipping, VCO is recalibrated each time PLL is enabled; code calibrates only when the sequencer enables the PLL, not on entering tune
// RULE12 - Receive-on bit in idle starts sequencer toward receive
// RULE13 - Receive: same steps, then receive circuits, then modem receive
// RULE14 - Modem in receive does gain, status, bit sync, optional correction
// RULE15 - Status 02 shows FIFO, header, frequency errors, power state
// RULE16 - Interrupt output is active low
// RULE17 - Interrupt stays low until the holding flag register is read
// RULE18 - Only enabled events drive interrupt; disabled flags still readable
// RULE19 - Reading a flag register clears its enabled bits
// RULE20 - Mask bit gates flag at same position; any gated flag drives low
// RULE21 - Writing zero to mode register selects standby
// RULE22 - After reset the radio defaults to ready mode
`timescale 1ns/1ps
module radio_mode_sequencer_irq (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [31:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic [15:0] event_in,
   input wire logic [4:0] fifo_status_in,
   output logic irq_out_n,
   output logic low_power_regulator,
   output logic main_regulator,
   output logic wake_timer_en,
   output logic battery_detect_en,
   output logic xtal_en,
   output logic pll_en,
   output logic vco_cal,
   output logic pa_en,
   output logic rx_front_en,
   output logic modem_rx,
   output logic modem_tx,
   output logic [1:0] chip_power_state
);
   ////////////////////////////////////////////////////////////////////////
   logic [7:0] mode_ctrl;
   logic [7:0] xtal_ctrl;
   logic [7:0] seq_cfg;
   logic [7:0] mask_one;
   logic [7:0] mask_two;
   logic [7:0] flags_one;
   logic [7:0] flags_two;
   logic [15:0] ev_meta;
   logic [15:0] ev_sync;
   logic [15:0] ev_prev;
   logic [15:0] ev_rise;
   logic [15:0] sw_raise;
   logic aw_held;
   logic w_held;
   logic [31:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_go;
   logic rd_go;
   logic clr_one;
   logic clr_two;
   logic [7:0] rd_idx;
   logic [7:0] wr_idx;
   logic [7:0] next_rdata;
   logic rd_mapped;
   radio_ctrl_pkg::seq_state_e state;
   logic [31:0] timer;
   logic timer_done;
   logic pll_was_on;
   logic xtal_was_on;

   function automatic logic [7:0] word_index(input logic [31:0] addr);
      word_index = addr[9:2];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write: address and data accepted in any order
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign wr_go = aw_held && w_held && !s_axi_bvalid;
   assign wr_idx = word_index(aw_addr);
   assign s_axi_bresp = 2'h0;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 32'h0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Registers, low byte lane only except event raise, which takes bits 15:0 under byte strobe 0
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mode_ctrl <= radio_ctrl_pkg::mode_ctrl_reset; // [RULE22]
         xtal_ctrl <= radio_ctrl_pkg::xtal_ctrl_reset;
         seq_cfg <= radio_ctrl_pkg::seq_cfg_reset; // [RULE9]
         mask_one <= radio_ctrl_pkg::mask_one_reset;
         mask_two <= radio_ctrl_pkg::mask_two_reset;
         sw_raise <= 16'h0;
      end else begin
         sw_raise <= 16'h0;
         if (wr_go && w_strb[0]) begin
            if (wr_idx == radio_ctrl_pkg::idx_mode_ctrl) begin
               mode_ctrl <= w_data[7:0]; // [RULE21] [RULE1]
            end else if (wr_idx == radio_ctrl_pkg::idx_xtal_ctrl) begin
               xtal_ctrl <= w_data[7:0];
            end else if (wr_idx == radio_ctrl_pkg::idx_seq_cfg) begin
               seq_cfg <= w_data[7:0];
            end else if (wr_idx == radio_ctrl_pkg::idx_mask_one) begin
               mask_one <= w_data[7:0];
            end else if (wr_idx == radio_ctrl_pkg::idx_mask_two) begin
               mask_two <= w_data[7:0];
            end else if (wr_idx == radio_ctrl_pkg::idx_event_raise) begin
               sw_raise <= w_data[15:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read, one cycle after the address is taken
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign rd_idx = word_index(s_axi_araddr);
   assign clr_one = rd_go && rd_idx == radio_ctrl_pkg::idx_flags_one;
   assign clr_two = rd_go && rd_idx == radio_ctrl_pkg::idx_flags_two;

   always_comb begin
      next_rdata = 8'h00;
      rd_mapped = 1'b1;
      if (rd_idx == radio_ctrl_pkg::idx_device_state) begin
         next_rdata = {fifo_status_in, 1'b0, chip_power_state}; // [RULE15]
      end else if (rd_idx == radio_ctrl_pkg::idx_flags_one) begin
         next_rdata = flags_one; // [RULE18]
      end else if (rd_idx == radio_ctrl_pkg::idx_flags_two) begin
         next_rdata = flags_two;
      end else if (rd_idx == radio_ctrl_pkg::idx_mask_one) begin
         next_rdata = mask_one;
      end else if (rd_idx == radio_ctrl_pkg::idx_mask_two) begin
         next_rdata = mask_two;
      end else if (rd_idx == radio_ctrl_pkg::idx_mode_ctrl) begin
         next_rdata = mode_ctrl;
      end else if (rd_idx == radio_ctrl_pkg::idx_xtal_ctrl) begin
         next_rdata = xtal_ctrl;
      end else if (rd_idx == radio_ctrl_pkg::idx_seq_cfg) begin
         next_rdata = seq_cfg;
      end else if (rd_idx == radio_ctrl_pkg::idx_sequence) begin
         next_rdata = {4'h0, state};
      end else begin
         rd_mapped = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h0, next_rdata};
         s_axi_rresp <= rd_mapped ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event inputs come from other domains, so two flops first
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ev_meta <= 16'h0;
         ev_sync <= 16'h0;
         ev_prev <= 16'h0;
      end else begin
         ev_meta <= event_in;
         ev_sync <= ev_meta;
         ev_prev <= ev_sync;
      end
   end
   assign ev_rise = (ev_sync & ~ev_prev) | sw_raise;

   // New event wins over the read clear; disabled flags survive reads
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         flags_one <= 8'h00;
         flags_two <= 8'h00;
      end else begin
         flags_one <= (flags_one & ~(clr_one ? mask_one : 8'h00))
                      | ev_rise[7:0]; // [RULE19] [RULE18]
         flags_two <= (flags_two & ~(clr_two ? mask_two : 8'h00))
                      | ev_rise[15:8]; // [RULE19]
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         irq_out_n <= 1'b1;
      end else begin
         irq_out_n <= !(|(flags_one & mask_one) ||
                        |(flags_two & mask_two)); // [RULE16] [RULE17] [RULE20]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   assign timer_done = timer == 32'h0;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state <= radio_ctrl_pkg::st_idle;
         timer <= 32'h0;
         xtal_was_on <= 1'b0;
         pll_was_on <= 1'b0;
      end else begin
         if (!timer_done) begin
            timer <= timer - 32'h1;
         end
         case (state)
            radio_ctrl_pkg::st_idle: begin
               xtal_was_on <= xtal_en;
               pll_was_on <= pll_en;
               if (mode_ctrl[radio_ctrl_pkg::mode_txon_bit] ||
                   mode_ctrl[radio_ctrl_pkg::mode_rxon_bit]) begin
                  state <= radio_ctrl_pkg::st_regs; // [RULE7] [RULE12]
               end
            end
            radio_ctrl_pkg::st_regs: begin
               if (xtal_was_on) begin
                  state <= radio_ctrl_pkg::st_pll; // [RULE10]
               end else begin
                  timer <= 32'(radio_ctrl_pkg::xtal_wait_cycles);
                  state <= radio_ctrl_pkg::st_xtal; // [RULE8]
               end
            end
            radio_ctrl_pkg::st_xtal: begin
               if (timer_done) begin
                  state <= radio_ctrl_pkg::st_pll;
               end
            end
            radio_ctrl_pkg::st_pll: begin
               if (pll_was_on) begin
                  state <= mode_ctrl[radio_ctrl_pkg::mode_txon_bit] ?
                           radio_ctrl_pkg::st_pa :
                           radio_ctrl_pkg::st_rxen; // [RULE10]
                  timer <= 32'(radio_ctrl_pkg::pa_ramp_cycles);
               end else if (seq_cfg[radio_ctrl_pkg::seq_skipcal_bit]) begin
                  timer <= 32'(radio_ctrl_pkg::pll_settle_cycles);
                  state <= radio_ctrl_pkg::st_settle; // [RULE9]
               end else begin
                  timer <= 32'(radio_ctrl_pkg::cal_cycles);
                  state <= radio_ctrl_pkg::st_cal; // [RULE11]
               end
            end
            radio_ctrl_pkg::st_cal: begin
               if (timer_done) begin
                  timer <= 32'(radio_ctrl_pkg::pll_settle_cycles);
                  state <= radio_ctrl_pkg::st_settle;
               end
            end
            radio_ctrl_pkg::st_settle: begin
               if (timer_done) begin
                  timer <= 32'(radio_ctrl_pkg::pa_ramp_cycles);
                  state <= mode_ctrl[radio_ctrl_pkg::mode_txon_bit] ?
                           radio_ctrl_pkg::st_pa :
                           radio_ctrl_pkg::st_rxen; // [RULE8] [RULE13]
               end
            end
            radio_ctrl_pkg::st_pa: begin
               if (timer_done) begin
                  state <= radio_ctrl_pkg::st_tx;
               end
            end
            radio_ctrl_pkg::st_rxen: begin
               state <= radio_ctrl_pkg::st_rx; // [RULE13]
            end
            radio_ctrl_pkg::st_tx, radio_ctrl_pkg::st_rx: begin
               if (!mode_ctrl[radio_ctrl_pkg::mode_txon_bit] &&
                   !mode_ctrl[radio_ctrl_pkg::mode_rxon_bit]) begin
                  state <= radio_ctrl_pkg::st_idle;
               end
            end
            default: begin
               state <= radio_ctrl_pkg::st_idle;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Resource enables; outputs registered
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         low_power_regulator <= 1'b1;
         main_regulator <= 1'b1;
         wake_timer_en <= 1'b0;
         battery_detect_en <= 1'b0;
         xtal_en <= 1'b1;
         pll_en <= 1'b0;
         vco_cal <= 1'b0;
         pa_en <= 1'b0;
         rx_front_en <= 1'b0;
         modem_rx <= 1'b0;
         modem_tx <= 1'b0;
         chip_power_state <= radio_ctrl_pkg::cps_idle;
      end else begin
         low_power_regulator <= 1'b1;
         main_regulator <= state != radio_ctrl_pkg::st_idle ||
                           (|mode_ctrl[1:0]) ||
                           mode_ctrl[radio_ctrl_pkg::mode_lbd_bit];
         wake_timer_en <= mode_ctrl[radio_ctrl_pkg::mode_wt_bit]; // [RULE1]
         battery_detect_en <=
            mode_ctrl[radio_ctrl_pkg::mode_lbd_en_bit]; // [RULE3]
         xtal_en <= mode_ctrl[radio_ctrl_pkg::mode_xton_bit] ||
                    mode_ctrl[radio_ctrl_pkg::mode_pllon_bit] ||
                    (state != radio_ctrl_pkg::st_idle &&
                     state != radio_ctrl_pkg::st_regs); // [RULE4] [RULE6]
         pll_en <= mode_ctrl[radio_ctrl_pkg::mode_pllon_bit] ||
                   (state != radio_ctrl_pkg::st_idle &&
                    state != radio_ctrl_pkg::st_regs &&
                    state != radio_ctrl_pkg::st_xtal); // [RULE6]
         vco_cal <= state == radio_ctrl_pkg::st_cal;
         pa_en <= state == radio_ctrl_pkg::st_pa ||
                  state == radio_ctrl_pkg::st_tx;
         rx_front_en <= state == radio_ctrl_pkg::st_rxen ||
                        state == radio_ctrl_pkg::st_rx;
         modem_rx <= state == radio_ctrl_pkg::st_rx; // [RULE14]
         modem_tx <= state == radio_ctrl_pkg::st_tx;
         chip_power_state <= state == radio_ctrl_pkg::st_tx ?
                             radio_ctrl_pkg::cps_tx :
                             state == radio_ctrl_pkg::st_rx ?
                             radio_ctrl_pkg::cps_rx :
                             radio_ctrl_pkg::cps_idle;
      end
   end
endmodule

// file: verif/host_model.sv
// Host model: register bus master in front of the radio control
`timescale 1ns/1ps
module host_model (
   input wire logic sys_clk,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_awaddr,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   output logic [31:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp
);
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      s_axi_wstrb = 4'hF;
   end
   ////////////////////////////////////////////////////////////////////////
   // Address and data offered together, each released when taken
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge sys_clk);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      s_axi_bready <= 1'b1;
      do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule

// file: verif/radio_irq_sva.sv
// Checker: bus handshakes, sequencer order and interrupt hold
`timescale 1ns/1ps
module radio_irq_sva (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic irq_out_n,
   input wire logic xtal_en,
   input wire logic pll_en,
   input wire logic vco_cal,
   input wire logic pa_en,
   input wire logic rx_front_en,
   input wire logic modem_rx,
   input wire logic modem_tx,
   input wire logic [1:0] chip_power_state
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////
   // Recent register access; a read or write may legally release irq
   logic rd_take;
   logic wr_take;
   logic [3:0] recent;
   assign rd_take = s_axi_arvalid & s_axi_arready;
   assign wr_take = s_axi_wvalid & s_axi_wready;
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         recent <= 4'hF;
      end else begin
         recent <= {recent[2:0], rd_take | wr_take};
      end
   end
   ////////////////////////////////////////////////////////////////////////
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read response dropped early");
   rd_turn_a: assert property (rd_take |=> s_axi_rvalid)
      else $error("read answer late");
   wr_turn_a: assert property (s_axi_awvalid && s_axi_awready && wr_take
      |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
   tx_order_a: assert property ($rose(pa_en) |-> pll_en && xtal_en)
      else $error("amplifier before synthesizer");
   rx_order_a: assert property ($rose(modem_rx) |->
      rx_front_en && pll_en) else $error("modem before front end");
   tx_state_a: assert property ($rose(modem_tx) |-> ##[0:1]
      chip_power_state == radio_ctrl_pkg::cps_tx) else $error("power state");
   cal_pll_a: assert property (vco_cal |-> pll_en)
      else $error("calibration without synthesizer");
   irq_hold_a: assert property (!irq_out_n && recent == 4'h0
      && !rd_take && !wr_take |=> !irq_out_n)
      else $error("interrupt released early");
endmodule
bind radio_mode_sequencer_irq radio_irq_sva chk_u (.*);

// file: verif/tb.sv
// Testbench: register access, idle modes, sequencer and interrupts
`timescale 1ns/1ps
module tb;
   logic sys_clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready, irq_out_n, vco_cal;
   logic low_power_regulator, main_regulator, wake_timer_en, pll_en, pa_en;
   logic battery_detect_en, xtal_en, rx_front_en, modem_rx, modem_tx;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, chip_power_state, rd_r;
   logic [15:0] event_in;
   logic [4:0] fifo_status_in;
   logic [31:0] rd_d;
   int miscompares = 0;
   int compares = 0;
   radio_mode_sequencer_irq dut_u (.*);
   host_model host_u (.*);
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string msg);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   // Byte address is four times the register index
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      host_u.wr({22'h0, i, 2'h0}, d);
   endtask
   task automatic rd(input logic [7:0] i);
      host_u.rd({22'h0, i, 2'h0}, rd_d, rd_r);
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic give_verdict;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      check(xtal_en, 1, "ready after reset");
      rd(radio_ctrl_pkg::idx_mode_ctrl);
      check(rd_d[7:0], 8'h01, "mode reset");
      rd(radio_ctrl_pkg::idx_mask_one);
      check(rd_d[7:0], 8'h00, "mask one reset");
      rd(radio_ctrl_pkg::idx_mask_two);
      check(rd_d[7:0], 8'h01, "mask two reset");
      rd(radio_ctrl_pkg::idx_seq_cfg);
      check(rd_d[7:0], 8'h00, "skip bit reset");
      rd(8'h3F);
      check(rd_r, 2'h2, "unmapped read");
   endtask
   task automatic t_modes;
      wr(radio_ctrl_pkg::idx_mode_ctrl, 8'h40);
      ticks(4);
      check({wake_timer_en, battery_detect_en, xtal_en, main_regulator,
             low_power_regulator}, 5'h11, "sleep");
      wr(radio_ctrl_pkg::idx_mode_ctrl, 8'h60);
      ticks(4);
      check({wake_timer_en, battery_detect_en, xtal_en, main_regulator},
            4'hD, "sensor");
      wr(radio_ctrl_pkg::idx_mode_ctrl, 8'h00);
      ticks(4);
      check({wake_timer_en, xtal_en, pll_en, main_regulator,
             low_power_regulator}, 5'h01, "standby");
      wr(radio_ctrl_pkg::idx_mode_ctrl, 8'h02);
      ticks(4);
      check({xtal_en, pll_en}, 2'h3, "tune");
      wr(radio_ctrl_pkg::idx_mode_ctrl, 8'h01);
      ticks(4);
      check({xtal_en, pll_en}, 2'h2, "ready");
   endtask
   // Masked flag stays set: irq must still release
   task automatic t_irq;
      wr(radio_ctrl_pkg::idx_mask_one, 8'h01);
      event_in <= 16'h0003;
      ticks(6);
      check(irq_out_n, 0, "enabled event");
      rd(radio_ctrl_pkg::idx_flags_one);
      check(rd_d[7:0], 8'h03, "flags one");
      ticks(2);
      check(irq_out_n, 1, "irq released");
      rd(radio_ctrl_pkg::idx_flags_one);
      check(rd_d[7:0], 8'h02, "masked flag kept");
      event_in <= 16'h0103;
      ticks(6);
      check(irq_out_n, 0, "second register event");
      rd(radio_ctrl_pkg::idx_flags_two);
      check(rd_d[7:0], 8'h01, "flags two");
      ticks(2);
      check(irq_out_n, 1, "irq released two");
      wr(radio_ctrl_pkg::idx_event_raise, 8'h04);
      rd(radio_ctrl_pkg::idx_flags_one);
      check(rd_d[7:0], 8'h06, "raised flag");
      check(irq_out_n, 1, "raised flag masked");
      event_in <= 16'h0000;
   endtask
   task automatic t_status;
      fifo_status_in <= 5'h15;
      ticks(2);
      rd(radio_ctrl_pkg::idx_device_state);
      check(rd_d[7:0] & 8'hFB, 8'hA8, "device state");
   endtask
   // From ready with skip set: no crystal wait, no calibration
   task automatic t_tx;
      int n;
      int cal;
      wr(radio_ctrl_pkg::idx_seq_cfg, 8'h01);
      wr(radio_ctrl_pkg::idx_xtal_ctrl, 8'h02);
      wr(radio_ctrl_pkg::idx_xtal_ctrl, 8'h00);
      wr(radio_ctrl_pkg::idx_mode_ctrl, 8'h09);
      cal = 0;
      for (n = 0; n < 30000 && pa_en !== 1'b1; n++) begin
         @(posedge sys_clk);
         if (vco_cal === 1'b1)
            cal++;
      end
      check(cal, 0, "calibration skipped");
      check(pa_en, 1, "amplifier ramped");
      for (n = 0; n < 3000 && modem_tx !== 1'b1; n++)
         @(posedge sys_clk);
      check(modem_tx, 1, "sending");
      ticks(2);
      check(chip_power_state, radio_ctrl_pkg::cps_tx, "tx state");
      rd(radio_ctrl_pkg::idx_sequence);
      check(rd_d[3:0], radio_ctrl_pkg::st_tx, "sequencer state");
      wr(radio_ctrl_pkg::idx_mode_ctrl, 8'h01);
      ticks(4);
      check({modem_tx, pa_en}, 2'h0, "back to ready");
   endtask
   task automatic t_rx;
      int n;
      int cal;
      wr(radio_ctrl_pkg::idx_seq_cfg, 8'h00);
      wr(radio_ctrl_pkg::idx_mode_ctrl, 8'h05);
      cal = 0;
      for (n = 0; n < 40000 && modem_rx !== 1'b1; n++) begin
         @(posedge sys_clk);
         if (vco_cal === 1'b1)
            cal++;
      end
      check(cal > 0, 1, "recalibrated");
      check({modem_rx, rx_front_en}, 2'h3, "receiving");
      ticks(2);
      check(chip_power_state, radio_ctrl_pkg::cps_rx, "rx state");
      wr(radio_ctrl_pkg::idx_mode_ctrl, 8'h01);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Whole run is about 51000 cycles; limit leaves margin
   initial begin
      #400000;
      miscompares++;
      give_verdict();
   end
   initial begin
      reset = 1'b1;
      event_in = 16'h0000;
      fifo_status_in = 5'h00;
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_modes();
      t_irq();
      t_status();
      t_tx();
      t_rx();
      give_verdict();
   end
endmodule
